// file: core/bsd_pkg.sv
// bsd_pkg: address windows, target codes and carriers of the
// boot secure address decoder.
// assumes one clock; all users reference names as bsd_pkg::name.
package bsd_pkg;

  // decoded targets
  typedef enum logic [3:0] {
    TGT_NONE     = 4'h0,
    TGT_ROM      = 4'h1,
    TGT_SRAM     = 4'h2,
    TGT_SRAM_BB  = 4'h3,
    TGT_PERI_BB  = 4'h4,
    TGT_FLASH_SP = 4'h5,
    TGT_GEN_SP   = 4'h6,
    TGT_PRCM     = 4'h7,
    TGT_HASH     = 4'h8,
    TGT_AES      = 4'h9,
    TGT_DES      = 4'hA,
    TGT_IRQ_CTRL = 4'hB,
    TGT_SECURE   = 4'hC
  } bsd_tgt_t;

  typedef enum logic {MST_CPU = 1'b0, MST_DMA = 1'b1} bsd_mst_t;
  typedef enum logic {PH_INIT = 1'b0, PH_APP = 1'b1} bsd_phase_t;

  typedef struct packed {
    bsd_mst_t master;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } bsd_req_t;

  typedef struct packed {
    logic err;
    logic [31:0] rdata;
  } bsd_rsp_t;

  // address windows, inclusive
  localparam logic [31:0] ROM_LO = 32'h0000_0000;
  localparam logic [31:0] ROM_HI = 32'h0007_FFFF;
  localparam logic [31:0] SRAM_LO = 32'h2000_0000;
  localparam logic [31:0] SRAM_HI = 32'h2003_FFFF;
  localparam logic [31:0] SRAM_BB_LO = 32'h2200_0000;
  localparam logic [31:0] SRAM_BB_HI = 32'h23FF_FFFF;
  localparam logic [31:0] SRAM_BB_TGT = 32'h2000_0000;
  localparam logic [31:0] PERI_BB_LO = 32'h4200_0000;
  localparam logic [31:0] PERI_BB_HI = 32'h43FF_FFFF;
  localparam logic [31:0] PERI_BB_TGT = 32'h4000_0000;
  localparam logic [31:0] FLASH_SP_LO = 32'h4402_0000;
  localparam logic [31:0] FLASH_SP_HI = 32'h4402_0FFF;
  localparam logic [31:0] GEN_SP_LO = 32'h4402_1000;
  localparam logic [31:0] GEN_SP_HI = 32'h4402_2FFF;
  localparam logic [31:0] PRCM_LO = 32'h4402_D000;
  localparam logic [31:0] PRCM_HI = 32'h4402_DFFF;
  localparam logic [31:0] HASH_LO = 32'h4403_5000;
  localparam logic [31:0] HASH_HI = 32'h4403_5FFF;
  localparam logic [31:0] AES_LO = 32'h4403_7000;
  localparam logic [31:0] AES_HI = 32'h4403_7FFF;
  localparam logic [31:0] DES_LO = 32'h4403_9000;
  localparam logic [31:0] DES_HI = 32'h4403_9FFF;
  localparam logic [31:0] IRQ_CTRL_LO = 32'hE000_E000;
  localparam logic [31:0] IRQ_CTRL_HI = 32'hE000_EFFF;
  localparam logic [31:0] TRACE_RSV_LO = 32'hE004_1000;
  localparam logic [31:0] TRACE_RSV_HI = 32'hE004_1FFF;
  localparam logic [31:0] SEC_LO = 32'h4402_6000;
  localparam logic [31:0] SEC_HI = 32'h4402_6FFF;

  // secure register word indexes and reset values
  localparam logic [1:0] SEC_FLAG_IDX = 2'h0;
  localparam logic [1:0] SEC_CPU_IDX = 2'h1;
  localparam logic [1:0] SEC_DMA_IDX = 2'h2;
  localparam logic [7:0] CPU_MID_RST = 8'h01;
  localparam logic [7:0] DMA_MID_RST = 8'h02;

  // sram retention in 64KB banks
  localparam int unsigned RET_BANKS = 4;
  localparam logic [3:0] RET_ALL = 4'hF;

  function automatic logic in_win(input logic [31:0] a,
                                  input logic [31:0] lo,
                                  input logic [31:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  // alias word n addresses bit n%8 of byte n/8
  function automatic logic [31:0] bb_target(input logic [31:0] base,
                                            input logic [31:0] a);
    return base + {12'h000, a[24:5]};
  endfunction

endpackage

// file: core/bsd_region_decode.sv
// bsd_region_decode: combinational map of an address to a target.
// assumes the caller applies phase, master and alias checks.
`timescale 1ns/1ps
module bsd_region_decode (
  input wire logic [31:0] addr,
  output bsd_pkg::bsd_tgt_t tgt
);

  always_comb begin
    tgt = bsd_pkg::TGT_NONE;
    if (bsd_pkg::in_win(addr, bsd_pkg::ROM_LO, bsd_pkg::ROM_HI)) begin
      tgt = bsd_pkg::TGT_ROM;
    end else if (bsd_pkg::in_win(addr, bsd_pkg::SRAM_LO,
                                 bsd_pkg::SRAM_HI)) begin
      tgt = bsd_pkg::TGT_SRAM;
    end else if (bsd_pkg::in_win(addr, bsd_pkg::SRAM_BB_LO,
                                 bsd_pkg::SRAM_BB_HI)) begin
      tgt = bsd_pkg::TGT_SRAM_BB;
    end else if (bsd_pkg::in_win(addr, bsd_pkg::PERI_BB_LO,
                                 bsd_pkg::PERI_BB_HI)) begin
      tgt = bsd_pkg::TGT_PERI_BB;
    end else if (bsd_pkg::in_win(addr, bsd_pkg::FLASH_SP_LO,
                                 bsd_pkg::FLASH_SP_HI)) begin
      tgt = bsd_pkg::TGT_FLASH_SP;
    end else if (bsd_pkg::in_win(addr, bsd_pkg::GEN_SP_LO,
                                 bsd_pkg::GEN_SP_HI)) begin
      tgt = bsd_pkg::TGT_GEN_SP;
    end else if (bsd_pkg::in_win(addr, bsd_pkg::PRCM_LO,
                                 bsd_pkg::PRCM_HI)) begin
      tgt = bsd_pkg::TGT_PRCM;
    end else if (bsd_pkg::in_win(addr, bsd_pkg::HASH_LO,
                                 bsd_pkg::HASH_HI)) begin
      tgt = bsd_pkg::TGT_HASH;
    end else if (bsd_pkg::in_win(addr, bsd_pkg::AES_LO,
                                 bsd_pkg::AES_HI)) begin
      tgt = bsd_pkg::TGT_AES;
    end else if (bsd_pkg::in_win(addr, bsd_pkg::DES_LO,
                                 bsd_pkg::DES_HI)) begin
      tgt = bsd_pkg::TGT_DES;
    end else if (bsd_pkg::in_win(addr, bsd_pkg::IRQ_CTRL_LO,
                                 bsd_pkg::IRQ_CTRL_HI)) begin
      tgt = bsd_pkg::TGT_IRQ_CTRL;
    end else if (bsd_pkg::in_win(addr, bsd_pkg::SEC_LO,
                                 bsd_pkg::SEC_HI)) begin
      tgt = bsd_pkg::TGT_SECURE;
    end
    // trace reserve falls through to none
  end

endmodule

// file: core/bsd_secure_regs.sv
// bsd_secure_regs: first-boot flag and master identities.
// assumes wr_en is already gated by the boot phase; srst is power-on.
`timescale 1ns/1ps
module bsd_secure_regs (
  input wire logic clk,
  input wire logic srst,
  input wire logic wr_en,
  input wire logic [1:0] idx,
  input wire logic [31:0] wdata,
  output logic flag,
  output logic [7:0] cpu_mid,
  output logic [7:0] dma_mid,
  output logic [31:0] rdata
);

  logic next_flag;
  logic [7:0] next_cpu_mid;
  logic [7:0] next_dma_mid;

  always_comb begin
    next_flag = flag;
    next_cpu_mid = cpu_mid;
    next_dma_mid = dma_mid;
    rdata = 32'h0000_0000;
    case (idx)
      bsd_pkg::SEC_FLAG_IDX: begin
        rdata = {31'h0000_0000, flag};
        // software may only clear the flag
        if (wr_en) begin
          next_flag = flag & wdata[0];
        end
      end
      bsd_pkg::SEC_CPU_IDX: begin
        rdata = {24'h00_0000, cpu_mid};
        if (wr_en) begin
          next_cpu_mid = wdata[7:0];
        end
      end
      bsd_pkg::SEC_DMA_IDX: begin
        rdata = {24'h00_0000, dma_mid};
        if (wr_en) begin
          next_dma_mid = wdata[7:0];
        end
      end
      default: ;
    endcase
  end

  // only power-on reset sets the flag
  always_ff @(posedge clk) begin
    if (srst) begin
      flag <= 1'b1;
      cpu_mid <= bsd_pkg::CPU_MID_RST;
      dma_mid <= bsd_pkg::DMA_MID_RST;
    end else begin
      flag <= next_flag;
      cpu_mid <= next_cpu_mid;
      dma_mid <= next_dma_mid;
    end
  end

endmodule

// file: core/bsd_top.sv
// bsd_top: system address decoder with boot-phase security gate.
// assumes srst is power-on reset and self_rst_req is the core's own
// reset request; each request is answered on the next clock, except one made while self_rst_req is high, which gets no answer.
//
// How it works
// - rom answers at 0x0000_0000 to 0x0007_FFFF.
// - sram answers at 0x2000_0000 to 0x2003_FFFF, 256KB.
// - 0x2200_0000..0x23FF_FFFF aliases single bits of 0x2000_0000 up.
// - 0x4200_0000..0x43FF_FFFF aliases single bits of peripherals.
// - 0x4402_0000..0x4402_0FFF goes to flash serial port.
// - 0x4402_1000..0x4402_2FFF goes to general serial port.
// - 0x4402_D000..0x4402_DFFF goes to power reset clock manager.
// - crypto range holds hash, aes, des apertures of 4KB each.
// - 0xE000_E000..0xE000_EFFF goes to interrupt controller for the processor core; transfer engine refused.
// - trace window 0xE004_1000..0xE004_1FFF stays unmapped.
// - sram retention in deep sleep chosen in 64KB steps.
// - transfer engine may read and write sram.
// - init phase has full access; app phase runs user code.
// - power-on reset sets the first-boot flag.
// - rom entry stub reads the flag to pick boot kind.
// - secure region reachable only in device-init phase.
// - flag set means device-init code runs from rom.
// - first boot clears flag and changes both master identities.
// - flag and identities live in the secure region.
// - self reset starts second boot, flag not set again.
// - second boot sees flag clear and new identity.
// - after second boot secure region blocked until power cycle.
`timescale 1ns/1ps
module bsd_top (
  input wire logic clk,
  input wire logic srst,
  input wire logic req_valid,
  input wire bsd_pkg::bsd_req_t req,
  input wire logic self_rst_req,
  input wire logic sleep_enter,
  input wire logic sleep_exit,
  input wire logic [2:0] retain_steps,
  output logic rsp_valid,
  output bsd_pkg::bsd_rsp_t rsp,
  output bsd_pkg::bsd_tgt_t tgt_sel,
  output logic [31:0] tgt_addr,
  output logic [2:0] tgt_bit,
  output logic tgt_write,
  output logic [31:0] tgt_wdata,
  output logic core_rst,
  output logic boot_first,
  output logic init_phase,
  output logic [7:0] cpu_mid,
  output logic [7:0] dma_mid,
  output logic [3:0] sram_retain
);

  bsd_pkg::bsd_tgt_t dec_tgt;
  bsd_pkg::bsd_phase_t phase;
  bsd_pkg::bsd_phase_t next_phase;
  logic sec_wr;
  logic [31:0] sec_rdata;
  logic deny;
  logic next_rsp_valid;
  bsd_pkg::bsd_rsp_t next_rsp;
  bsd_pkg::bsd_tgt_t next_tgt_sel;
  logic [31:0] next_tgt_addr;
  logic [2:0] next_tgt_bit;
  logic next_tgt_write;
  logic [31:0] next_tgt_wdata;
  logic next_core_rst;
  logic [3:0] next_sram_retain;

  bsd_region_decode u_decode (
    .addr(req.addr),
    .tgt(dec_tgt)
  );

  bsd_secure_regs u_secure (
    .clk(clk),
    .srst(srst),
    .wr_en(sec_wr),
    .idx(req.addr[3:2]),
    .wdata(req.wdata),
    .flag(boot_first),
    .cpu_mid(cpu_mid),
    .dma_mid(dma_mid),
    .rdata(sec_rdata)
  );

  // request gate and routing
  always_comb begin
    deny = 1'b0;
    sec_wr = 1'b0;
    next_rsp_valid = 1'b0;
    next_rsp = '0;
    next_tgt_sel = bsd_pkg::TGT_NONE;
    next_tgt_addr = 32'h0000_0000;
    next_tgt_bit = 3'h0;
    next_tgt_write = 1'b0;
    next_tgt_wdata = 32'h0000_0000;
    if (req_valid && !self_rst_req) begin
      next_rsp_valid = 1'b1;
      next_tgt_sel = dec_tgt;
      next_tgt_addr = req.addr;
      next_tgt_write = req.write;
      next_tgt_wdata = req.wdata;
      case (dec_tgt)
        bsd_pkg::TGT_SRAM_BB: begin
          // alias to sram byte and bit
          next_tgt_addr = bsd_pkg::bb_target(bsd_pkg::SRAM_BB_TGT,
                                             req.addr);
          next_tgt_bit = req.addr[4:2];
          if (next_tgt_addr > bsd_pkg::SRAM_HI) begin
            deny = 1'b1;
          end
        end
        bsd_pkg::TGT_PERI_BB: begin
          // alias to peripheral byte and bit
          next_tgt_addr = bsd_pkg::bb_target(bsd_pkg::PERI_BB_TGT,
                                             req.addr);
          next_tgt_bit = req.addr[4:2];
        end
        bsd_pkg::TGT_IRQ_CTRL: begin
          if (req.master == bsd_pkg::MST_DMA) begin
            deny = 1'b1;
          end
        end
        bsd_pkg::TGT_SECURE: begin
          // secure region open in init phase
          if (phase == bsd_pkg::PH_INIT) begin
            sec_wr = req.write;
            if (!req.write) begin
              next_rsp.rdata = sec_rdata;
            end
          end else begin
            deny = 1'b1;
          end
        end
        bsd_pkg::TGT_NONE: begin
          deny = 1'b1;
        end
        default: ;
      endcase
      if (deny) begin
        next_rsp.err = 1'b1;
        next_rsp.rdata = 32'h0000_0000;
        next_tgt_sel = bsd_pkg::TGT_NONE;
        next_tgt_addr = 32'h0000_0000;
        next_tgt_bit = 3'h0;
        next_tgt_write = 1'b0;
        next_tgt_wdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rsp_valid <= 1'b0;
      rsp <= '0;
      tgt_sel <= bsd_pkg::TGT_NONE;
      tgt_addr <= 32'h0000_0000;
      tgt_bit <= 3'h0;
      tgt_write <= 1'b0;
      tgt_wdata <= 32'h0000_0000;
    end else begin
      rsp_valid <= next_rsp_valid;
      rsp <= next_rsp;
      tgt_sel <= next_tgt_sel;
      tgt_addr <= next_tgt_addr;
      tgt_bit <= next_tgt_bit;
      tgt_write <= next_tgt_write;
      tgt_wdata <= next_tgt_wdata;
    end
  end

  // boot phase and core self reset
  always_comb begin
    next_phase = phase;
    next_core_rst = self_rst_req;
    // self reset leaves flag, picks next phase
    if (self_rst_req) begin
      // flag still set keeps device-init phase
      if (boot_first) begin
        next_phase = bsd_pkg::PH_INIT;
      end else begin
        next_phase = bsd_pkg::PH_APP;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      phase <= bsd_pkg::PH_INIT;
      init_phase <= 1'b1;
      core_rst <= 1'b0;
    end else begin
      phase <= next_phase;
      init_phase <= (next_phase == bsd_pkg::PH_INIT);
      core_rst <= next_core_rst;
    end
  end

  // deep sleep retention banks
  always_comb begin
    next_sram_retain = sram_retain;
    if (sleep_enter) begin
      next_sram_retain = 4'h0;
      for (int i = 0; i < bsd_pkg::RET_BANKS; i++) begin
        if (i < int'(retain_steps)) begin
          next_sram_retain[i] = 1'b1;
        end
      end
    end else if (sleep_exit) begin
      next_sram_retain = bsd_pkg::RET_ALL;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sram_retain <= bsd_pkg::RET_ALL;
    end else begin
      sram_retain <= next_sram_retain;
    end
  end

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  logic go;
  assign go = req_valid && !self_rst_req;

  chk_rom_route: assert property (
    go && bsd_pkg::in_win(req.addr, bsd_pkg::ROM_LO, bsd_pkg::ROM_HI)
    |=> rsp_valid && !rsp.err && tgt_sel == bsd_pkg::TGT_ROM)
    else $error("rom access misrouted");

  chk_sram_route: assert property (
    go && bsd_pkg::in_win(req.addr, bsd_pkg::SRAM_LO,
                          bsd_pkg::SRAM_HI)
    |=> tgt_sel == bsd_pkg::TGT_SRAM && tgt_addr == $past(req.addr))
    else $error("sram access misrouted");

  chk_sram_alias: assert property (
    go && req.addr == 32'h2200_0084
    |=> tgt_sel == bsd_pkg::TGT_SRAM_BB && tgt_addr == 32'h2000_0004
        && tgt_bit == 3'h1 && !rsp.err)
    else $error("sram alias address wrong");

  chk_peri_alias: assert property (
    go && req.addr == 32'h43FF_FFFC
    |=> tgt_sel == bsd_pkg::TGT_PERI_BB && tgt_addr == 32'h400F_FFFF
        && tgt_bit == 3'h7)
    else $error("peripheral alias address wrong");

  chk_serial_ports: assert property (
    go && req.addr == 32'h4402_0FFC
    |=> tgt_sel == bsd_pkg::TGT_FLASH_SP && rsp_valid && !rsp.err
        && tgt_addr == 32'h4402_0FFC)
    else $error("flash serial port misrouted");

  chk_gen_port: assert property (
    go && req.addr == 32'h4402_2FFC |=> tgt_sel == bsd_pkg::TGT_GEN_SP)
    else $error("general serial port misrouted");

  chk_prcm_route: assert property (
    go && req.addr == 32'h4402_D000 |=> tgt_sel == bsd_pkg::TGT_PRCM)
    else $error("clock manager misrouted");

  chk_crypto_route: assert property (
    go && req.addr == 32'h4403_7FFC |=> tgt_sel == bsd_pkg::TGT_AES)
    else $error("crypto aperture misrouted");

  chk_irq_route: assert property (
    go && req.master == bsd_pkg::MST_CPU && req.addr == 32'hE000_E000
    |=> tgt_sel == bsd_pkg::TGT_IRQ_CTRL && !rsp.err)
    else $error("interrupt controller misrouted");

  chk_trace_rsvd: assert property (
    go && bsd_pkg::in_win(req.addr, bsd_pkg::TRACE_RSV_LO,
                          bsd_pkg::TRACE_RSV_HI)
    |=> rsp.err && tgt_sel == bsd_pkg::TGT_NONE)
    else $error("trace reserve selected a target");

  chk_retain_steps: assert property (
    sleep_enter && retain_steps == 3'h2 |=> sram_retain == 4'h3)
    else $error("retention mask wrong");

  chk_dma_sram: assert property (
    go && req.master == bsd_pkg::MST_DMA && req.write
    && req.addr == 32'h2003_FFFC
    |=> !rsp.err && tgt_write && tgt_sel == bsd_pkg::TGT_SRAM)
    else $error("transfer engine refused sram");

  chk_flag_por: assert property (
    $fell(srst) |-> boot_first && init_phase)
    else $error("flag not set by power-on");

  chk_self_keep: assert property (
    self_rst_req |=> core_rst && boot_first == $past(boot_first)
    && init_phase == $past(boot_first))
    else $error("self reset handled wrongly");

  chk_app_sticky: assert property (
    !init_phase |=> !init_phase [*3])
    else $error("left application phase without power-on");

  chk_sec_block: assert property (
    go && !init_phase && dec_tgt == bsd_pkg::TGT_SECURE
    |-> !sec_wr ##1 rsp.err && rsp.rdata == 32'h0000_0000
        && tgt_sel == bsd_pkg::TGT_NONE)
    else $error("secure access not blocked");

  chk_sec_open: assert property (
    go && init_phase && dec_tgt == bsd_pkg::TGT_SECURE
    |=> rsp_valid && !rsp.err)
    else $error("secure access refused in init phase");

  chk_unmapped: assert property (
    go && dec_tgt == bsd_pkg::TGT_NONE
    |=> rsp_valid && rsp.err && !tgt_write
        && tgt_sel == bsd_pkg::TGT_NONE)
    else $error("unmapped access not refused");

  cov_sec_write: cover property (
    go && init_phase && req.write && dec_tgt == bsd_pkg::TGT_SECURE);
  cov_second_boot: cover property (
    self_rst_req && !boot_first ##1 !init_phase);
  cov_blocked: cover property (
    go && !init_phase && dec_tgt == bsd_pkg::TGT_SECURE);
  cov_alias: cover property (
    go && dec_tgt == bsd_pkg::TGT_SRAM_BB);
  cov_dma_irq: cover property (
    go && req.master == bsd_pkg::MST_DMA && dec_tgt == bsd_pkg::TGT_IRQ_CTRL);

endmodule

// file: testbench/bsd_master_model.sv
// bsd_master_model: processor core and transfer engine bus masters.
// assumes requests are taken on the rising edge, answered one later.
`timescale 1ns/1ps
module bsd_master_model (
  input wire logic clk,
  output logic req_valid,
  output bsd_pkg::bsd_req_t req
);
  initial begin
    req_valid = 1'b0;
    req = '0;
  end

  // one word held to its taking edge; slow masters idle first
  task automatic access(input bsd_pkg::bsd_mst_t m, input logic w,
      input logic [31:0] a, input logic [31:0] d, input int slow);
    repeat (slow) @(posedge clk);
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{master: m, write: w, addr: a, wdata: d};
    @(posedge clk);
    req_valid <= 1'b0;
    // released bus shows no stale value
    req <= ~req;
    #1;
  endtask
endmodule

// file: testbench/bsd_testbench.sv
// testbench: self-checking bench of the boot secure address decoder.
// assumes bsd_top answers each request on the next clock edge.
`timescale 1ns/1ps
module testbench;
  logic clk;
  logic srst;
  logic req_valid;
  bsd_pkg::bsd_req_t req;
  logic self_rst_req;
  logic sleep_enter;
  logic sleep_exit;
  logic [2:0] retain_steps;
  int errors;
  int checks;

  bsd_master_model u_mst (.clk(clk), .req_valid(req_valid), .req(req));

  bsd_top u_dut (
    .clk(clk), .srst(srst), .req_valid(req_valid), .req(req),
    .self_rst_req(self_rst_req), .sleep_enter(sleep_enter),
    .sleep_exit(sleep_exit), .retain_steps(retain_steps),
    .rsp_valid(), .rsp(), .tgt_sel(), .tgt_addr(), .tgt_bit(),
    .tgt_write(), .tgt_wdata(), .core_rst(), .boot_first(),
    .init_phase(), .cpu_mid(), .dma_mid(), .sram_retain()
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // access and judge answer, target, error and read data
  task automatic acc(input bsd_pkg::bsd_mst_t m, input logic w,
      input logic [31:0] a, input logic [31:0] d,
      input bsd_pkg::bsd_tgt_t t, input logic [31:0] rd);
    u_mst.access(m, w, a, d, int'(a[3:2]));
    chk(u_dut.rsp_valid, 32'h1);
    chk(u_dut.tgt_sel, t);
    chk(u_dut.rsp.err, t == bsd_pkg::TGT_NONE);
    chk(u_dut.rsp.rdata, rd);
    chk(u_dut.tgt_write, w && t != bsd_pkg::TGT_NONE);
  endtask

  task automatic self_reset(input logic exp_init);
    @(posedge clk);
    self_rst_req <= 1'b1;
    @(posedge clk);
    self_rst_req <= 1'b0;
    #1;
    chk(u_dut.core_rst, 32'h1);
    chk(u_dut.init_phase, exp_init);
    @(posedge clk);
    #1;
    chk(u_dut.core_rst, 32'h0);
  endtask

  task automatic t_reset_vals();
    chk(u_dut.boot_first, 32'h1);
    chk(u_dut.init_phase, 32'h1);
    chk(u_dut.cpu_mid, bsd_pkg::CPU_MID_RST);
    chk(u_dut.dma_mid, bsd_pkg::DMA_MID_RST);
    chk(u_dut.sram_retain, bsd_pkg::RET_ALL);
  endtask

  task automatic t_map();
    logic [31:0] a [14];
    bsd_pkg::bsd_tgt_t t [14];
    a = '{32'h0000_0000, 32'h0007_FFFC, 32'h0008_0000, 32'h2003_FFFC,
          32'h2004_0000, 32'h4402_0FFC, 32'h4402_2FFC, 32'h4402_D000,
          32'h4403_5000, 32'h4403_7FFC, 32'h4403_9000, 32'h4403_0000,
          32'hE000_E000, 32'hE004_1000};
    t = '{bsd_pkg::TGT_ROM, bsd_pkg::TGT_ROM, bsd_pkg::TGT_NONE,
          bsd_pkg::TGT_SRAM, bsd_pkg::TGT_NONE, bsd_pkg::TGT_FLASH_SP,
          bsd_pkg::TGT_GEN_SP, bsd_pkg::TGT_PRCM, bsd_pkg::TGT_HASH,
          bsd_pkg::TGT_AES, bsd_pkg::TGT_DES, bsd_pkg::TGT_NONE,
          bsd_pkg::TGT_IRQ_CTRL, bsd_pkg::TGT_NONE};
    for (int i = 0; i < 14; i++) begin
      acc(bsd_pkg::MST_CPU, 1'b0, a[i], 32'h0, t[i], 32'h0);
      chk(u_dut.tgt_addr, (t[i] == bsd_pkg::TGT_NONE) ? 32'h0 : a[i]);
    end
  endtask

  task automatic t_alias();
    acc(bsd_pkg::MST_CPU, 1'b0, 32'h2200_0084, 32'h0,
        bsd_pkg::TGT_SRAM_BB, 32'h0);
    chk(u_dut.tgt_addr, 32'h2000_0004);
    chk(u_dut.tgt_bit, 32'h1);
    acc(bsd_pkg::MST_CPU, 1'b1, 32'h43FF_FFFC, 32'h1,
        bsd_pkg::TGT_PERI_BB, 32'h0);
    chk(u_dut.tgt_addr, 32'h400F_FFFF);
    chk(u_dut.tgt_bit, 32'h7);
    acc(bsd_pkg::MST_CPU, 1'b0, 32'h2280_0000, 32'h0,
        bsd_pkg::TGT_NONE, 32'h0);
  endtask

  task automatic t_dma_sram();
    acc(bsd_pkg::MST_DMA, 1'b1, 32'h2003_FFFC, 32'hC3A5_0F1E,
        bsd_pkg::TGT_SRAM, 32'h0);
    chk(u_dut.tgt_wdata, 32'hC3A5_0F1E);
    acc(bsd_pkg::MST_DMA, 1'b0, 32'hE000_E000, 32'h0,
        bsd_pkg::TGT_NONE, 32'h0);
  endtask

  task automatic t_boot();
    logic [31:0] s;
    s = bsd_pkg::SEC_LO;
    acc(bsd_pkg::MST_CPU, 1'b0, s, 32'h0, bsd_pkg::TGT_SECURE,
        32'h1);
    acc(bsd_pkg::MST_CPU, 1'b1, s + 32'h4, 32'h5A, bsd_pkg::TGT_SECURE,
        32'h0);
    chk(u_dut.cpu_mid, 32'h5A);
    acc(bsd_pkg::MST_CPU, 1'b1, s + 32'h8, 32'hA5, bsd_pkg::TGT_SECURE,
        32'h0);
    chk(u_dut.dma_mid, 32'hA5);
    self_reset(1'b1);
    chk(u_dut.boot_first, 32'h1);
    acc(bsd_pkg::MST_CPU, 1'b1, s, 32'h0, bsd_pkg::TGT_SECURE,
        32'h0);
    chk(u_dut.boot_first, 32'h0);
    self_reset(1'b0);
    chk(u_dut.boot_first, 32'h0);
    chk(u_dut.cpu_mid, 32'h5A);
    acc(bsd_pkg::MST_CPU, 1'b1, s + 32'h4, 32'h33, bsd_pkg::TGT_NONE,
        32'h0);
    chk(u_dut.cpu_mid, 32'h5A);
    acc(bsd_pkg::MST_CPU, 1'b0, s + 32'h4, 32'h0, bsd_pkg::TGT_NONE,
        32'h0);
    acc(bsd_pkg::MST_CPU, 1'b0, 32'h0, 32'h0, bsd_pkg::TGT_ROM,
        32'h0);
    self_reset(1'b0);
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    #1;
    t_reset_vals();
  endtask

  task automatic t_sleep();
    for (int n = 0; n < 6; n++) begin
      @(posedge clk);
      sleep_enter <= 1'b1;
      retain_steps <= 3'(n);
      @(posedge clk);
      sleep_enter <= 1'b0;
      #1;
      chk(u_dut.sram_retain, (n > 4) ? 32'hF : (32'h1 << n) - 32'h1);
      @(posedge clk);
      sleep_exit <= 1'b1;
      @(posedge clk);
      sleep_exit <= 1'b0;
      #1;
      chk(u_dut.sram_retain, 32'hF);
    end
  endtask

  initial begin
    #100000;
    errors++;
    conclude();
  end

  initial begin
    errors = 0;
    checks = 0;
    srst = 1'b1;
    self_rst_req = 1'b0;
    sleep_enter = 1'b0;
    sleep_exit = 1'b0;
    retain_steps = 3'h0;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    #1;
    t_reset_vals();
    t_map();
    t_alias();
    t_dma_sram();
    t_boot();
    t_sleep();
    conclude();
  end
endmodule
